/* File: pwos_pkg.sv */
package pwos_pkg;
    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [11:0] OFF_OUTPUT_B_ACTIONS = 12'h0C4;
    localparam logic [11:0] OFF_DEADTIME_CONFIG = 12'h0C8;
    localparam logic [11:0] OFF_FALLING_DELAY_SHADOW = 12'h0CC;
    localparam logic [11:0] OFF_RISING_DELAY_SHADOW = 12'h0D0;
    localparam logic [11:0] OFF_CARRIER_CONFIG = 12'h0D4;
    localparam logic [11:0] OFF_FAULT_ACTION_CONFIG = 12'h0D8;
    localparam logic [11:0] OFF_FAULT_FORCE_CONFIG = 12'h0DC;
    localparam logic [11:0] OFF_FAULT_STATUS = 12'h0E0;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [31:0] RST_DEADTIME_CONFIG = 32'h0001_8000;
    localparam logic [31:0] RST_ZERO = 32'h0000_0000;

    // ------------------------------------------------------------
    // deadtime_config fields
    // ------------------------------------------------------------
    localparam int DT_FALL_UPD_LSB = 0;
    localparam int DT_RISE_UPD_LSB = 4;
    localparam int DT_DUAL_EDGE_B = 8;
    localparam int DT_A_SWAP = 9;
    localparam int DT_B_SWAP = 10;
    localparam int DT_RISE_INSEL = 11;
    localparam int DT_FALL_INSEL = 12;
    localparam int DT_RISE_OUTINV = 13;
    localparam int DT_FALL_OUTINV = 14;
    localparam int DT_A_BYPASS = 15;
    localparam int DT_B_BYPASS = 16;
    localparam int DT_CLK_SEL = 17;

    // ------------------------------------------------------------
    // carrier_config fields
    // ------------------------------------------------------------
    localparam int CR_ENABLE = 0;
    localparam int CR_DIV_LSB = 1;
    localparam int CR_WIDTH_LSB = 8;
    localparam int CR_OUT_INV = 12;
    localparam int CR_IN_INV = 13;
    localparam int CR_PERIOD_TICKS = 8;

    // ------------------------------------------------------------
    // fault_action_config / fault_force_config / status fields
    // ------------------------------------------------------------
    localparam int FA_SW_CYCLE_EN = 0;
    localparam int FA_F_CYCLE_LSB = 1;
    localparam int FA_SW_ONE_SHOT_EN = 4;
    localparam int FA_F_ONE_SHOT_LSB = 5;
    localparam int FA_A_ACT_LSB = 8;
    localparam int FA_B_ACT_LSB = 16;
    localparam int FF_CLEAR_TOGGLE = 0;
    localparam int FF_REFRESH_LSB = 1;
    localparam int FF_CYCLE_TOGGLE = 3;
    localparam int FF_ONE_SHOT_TOGGLE = 4;
    localparam int ST_CYCLE_ACTIVE = 0;
    localparam int ST_ONE_SHOT_ACTIVE = 1;

    // ------------------------------------------------------------
    // action encoding
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ACT_KEEP = 2'b00,
        ACT_LOW = 2'b01,
        ACT_HIGH = 2'b10,
        ACT_TOGGLE = 2'b11
    } pwos_action_t;
endpackage : pwos_pkg

/* File: pwos_top.sv */
// Chosen here: the APB interface to the registers.
`timescale 1ns/10ps
module pwos_top #(
    parameter int DELAY_W = 16
) (
    // clock, reset, clock enable
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic CE,
    // apb slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // timer events and direction
    input wire logic TIMER_ZERO_MATCH,
    input wire logic TIMER_PERIOD_MATCH,
    input wire logic COMPARE_A_MATCH,
    input wire logic COMPARE_B_MATCH,
    input wire logic TRIGGER_EVENT_ZERO,
    input wire logic TRIGGER_EVENT_ONE,
    input wire logic TIMER_COUNT_DOWN,
    input wire logic SYNC_EVENT,
    input wire logic TIMER_PRESCALED_CLOCK,
    // fault events, level
    input wire logic FAULT_EVENT_ZERO,
    input wire logic FAULT_EVENT_ONE,
    input wire logic FAULT_EVENT_TWO,
    // generator output A from the action stage
    input wire logic OUTPUT_A_IN,
    // gate driver outputs
    output logic OUTPUT_A,
    output logic OUTPUT_B
);
    // ------------------------------------------------------------
    // register file
    // ------------------------------------------------------------
    logic [31:0] b_act_q, dt_cfg_q, fed_sh_q, red_sh_q;
    logic [31:0] cr_cfg_q, fa_cfg_q, ff_cfg_q, ff_prev_q;
    logic [DELAY_W-1:0] red_act_q, fed_act_q;
    logic os_on_q, cyc_on_q;
    logic wr_en;
    logic rd_ok;
    logic [31:0] rd_data;

    // read mux and decode, shared by setup-phase registering
    always_comb begin
        rd_ok = 1'b1;
        rd_data = pwos_pkg::RST_ZERO;
        if (PADDR == pwos_pkg::OFF_OUTPUT_B_ACTIONS) begin
            rd_data = b_act_q;
        end else if (PADDR == pwos_pkg::OFF_DEADTIME_CONFIG) begin
            rd_data = dt_cfg_q;
        end else if (PADDR == pwos_pkg::OFF_FALLING_DELAY_SHADOW) begin
            rd_data = fed_sh_q;
        end else if (PADDR == pwos_pkg::OFF_RISING_DELAY_SHADOW) begin
            rd_data = red_sh_q;
        end else if (PADDR == pwos_pkg::OFF_CARRIER_CONFIG) begin
            rd_data = cr_cfg_q;
        end else if (PADDR == pwos_pkg::OFF_FAULT_ACTION_CONFIG) begin
            rd_data = fa_cfg_q;
        end else if (PADDR == pwos_pkg::OFF_FAULT_FORCE_CONFIG) begin
            rd_data = ff_cfg_q;
        end else if (PADDR == pwos_pkg::OFF_FAULT_STATUS) begin
            rd_data = {30'h0000_0000, os_on_q, cyc_on_q};
        end else begin
            rd_ok = 1'b0;
        end
    end

    // one wait-free access: ready rises in the access phase
    assign wr_en = PSEL & PENABLE & PWRITE & PREADY & CE;

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            PREADY <= 1'b0;
            PRDATA <= pwos_pkg::RST_ZERO;
            PSLVERR <= 1'b0;
        end else if (CE) begin
            PREADY <= PSEL & ~PENABLE;
            PSLVERR <= PSEL & ~PENABLE & ~rd_ok;
            if (PSEL && !PENABLE && !PWRITE) begin
                PRDATA <= rd_data;
            end
        end
    end

    // software-writable registers; delays only reach shadows
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            b_act_q <= pwos_pkg::RST_ZERO;
            dt_cfg_q <= pwos_pkg::RST_DEADTIME_CONFIG;
            fed_sh_q <= pwos_pkg::RST_ZERO;
            red_sh_q <= pwos_pkg::RST_ZERO;
            cr_cfg_q <= pwos_pkg::RST_ZERO;
            fa_cfg_q <= pwos_pkg::RST_ZERO;
            ff_cfg_q <= pwos_pkg::RST_ZERO;
        end else if (wr_en) begin
            if (PADDR == pwos_pkg::OFF_OUTPUT_B_ACTIONS) begin
                b_act_q <= PWDATA;
            end else if (PADDR == pwos_pkg::OFF_DEADTIME_CONFIG) begin
                dt_cfg_q <= PWDATA;
            end else if (PADDR == pwos_pkg::OFF_FALLING_DELAY_SHADOW) begin
                fed_sh_q <= PWDATA;
            end else if (PADDR == pwos_pkg::OFF_RISING_DELAY_SHADOW) begin
                red_sh_q <= PWDATA;
            end else if (PADDR == pwos_pkg::OFF_CARRIER_CONFIG) begin
                cr_cfg_q <= PWDATA;
            end else if (PADDR == pwos_pkg::OFF_FAULT_ACTION_CONFIG) begin
                fa_cfg_q <= PWDATA;
            end else if (PADDR == pwos_pkg::OFF_FAULT_FORCE_CONFIG) begin
                ff_cfg_q <= PWDATA;
            end
        end
    end

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // apply one action code to a level
    function automatic logic apply_act(input logic cur,
                                       input logic [1:0] act);
        case (act)
            pwos_pkg::ACT_LOW: apply_act = 1'b0;
            pwos_pkg::ACT_HIGH: apply_act = 1'b1;
            pwos_pkg::ACT_TOGGLE: apply_act = ~cur;
            default: apply_act = cur;
        endcase
    endfunction : apply_act

    // shadow-to-active load condition for a 4-bit method field
    function automatic logic upd_now(input logic [3:0] m, input logic z,
                                     input logic p, input logic s);
        upd_now = (m == 4'h0) ||
                  (!m[3] && ((m[0] && z) || (m[1] && p) || (m[2] && s)));
    endfunction : upd_now

    // ------------------------------------------------------------
    // output B action stage
    // ------------------------------------------------------------
    logic [5:0] b_evt;
    logic b_gen_q;
    logic [3:0] b_base;

    assign b_evt = {TRIGGER_EVENT_ONE, TRIGGER_EVENT_ZERO, COMPARE_B_MATCH,
                    COMPARE_A_MATCH, TIMER_PERIOD_MATCH, TIMER_ZERO_MATCH};
    assign b_base = TIMER_COUNT_DOWN ? 4'hC : 4'h0;

    // later events in the list win when several coincide
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            b_gen_q <= 1'b0;
        end else if (CE) begin
            for (int i = 0; i < 6; i++) begin
                if (b_evt[i]) begin
                    b_gen_q <= apply_act(b_gen_q,
                        b_act_q[5'(b_base) + 5'(2*i) +: 2]);
                end
            end
        end
    end

    // ------------------------------------------------------------
    // dead-time generator
    // ------------------------------------------------------------
    logic dt_tick;
    logic red_in, fed_in, red_out_q, fed_out_q, a_dt, b_dt, a_pre, b_pre;
    logic [DELAY_W-1:0] red_cnt_q, fed_cnt_q;

    assign dt_tick = dt_cfg_q[pwos_pkg::DT_CLK_SEL] ?
                     TIMER_PRESCALED_CLOCK : 1'b1;

    // active delays follow the selected update moment
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            red_act_q <= '0;
            fed_act_q <= '0;
        end else if (CE) begin
            if (upd_now(dt_cfg_q[pwos_pkg::DT_RISE_UPD_LSB +: 4],
                        TIMER_ZERO_MATCH, TIMER_PERIOD_MATCH, SYNC_EVENT)) begin
                red_act_q <= red_sh_q[DELAY_W-1:0];
            end
            if (upd_now(dt_cfg_q[pwos_pkg::DT_FALL_UPD_LSB +: 4],
                        TIMER_ZERO_MATCH, TIMER_PERIOD_MATCH, SYNC_EVENT)) begin
                fed_act_q <= fed_sh_q[DELAY_W-1:0];
            end
        end
    end

    // input selection; dual-edge chains falling after rising on B
    assign red_in = dt_cfg_q[pwos_pkg::DT_RISE_INSEL] ?
                    b_gen_q : OUTPUT_A_IN;
    assign fed_in = dt_cfg_q[pwos_pkg::DT_DUAL_EDGE_B] ? red_out_q :
                    (dt_cfg_q[pwos_pkg::DT_FALL_INSEL] ?
                     b_gen_q : OUTPUT_A_IN);

    // rising delay: high only after the input held high long enough
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            red_cnt_q <= '0;
            red_out_q <= 1'b0;
        end else if (CE) begin
            if (!red_in) begin
                red_cnt_q <= '0;
                red_out_q <= 1'b0;
            end else if (dt_tick) begin
                if (red_cnt_q >= red_act_q) begin
                    red_out_q <= 1'b1;
                end else begin
                    red_cnt_q <= red_cnt_q + 1'b1;
                end
            end
        end
    end

    // falling delay: low only after the input held low long enough
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            fed_cnt_q <= '0;
            fed_out_q <= 1'b0;
        end else if (CE) begin
            if (fed_in) begin
                fed_cnt_q <= '0;
                fed_out_q <= 1'b1;
            end else if (dt_tick) begin
                if (fed_cnt_q >= fed_act_q) begin
                    fed_out_q <= 1'b0;
                end else begin
                    fed_cnt_q <= fed_cnt_q + 1'b1;
                end
            end
        end
    end

    // bypass, output invert and swap switches
    always_comb begin
        if (dt_cfg_q[pwos_pkg::DT_DUAL_EDGE_B]) begin
            a_dt = dt_cfg_q[pwos_pkg::DT_A_BYPASS] ? OUTPUT_A_IN :
                   OUTPUT_A_IN ^ dt_cfg_q[pwos_pkg::DT_RISE_OUTINV];
        end else begin
            a_dt = dt_cfg_q[pwos_pkg::DT_A_BYPASS] ? OUTPUT_A_IN :
                   red_out_q ^ dt_cfg_q[pwos_pkg::DT_RISE_OUTINV];
        end
        b_dt = dt_cfg_q[pwos_pkg::DT_B_BYPASS] ? b_gen_q :
               fed_out_q ^ dt_cfg_q[pwos_pkg::DT_FALL_OUTINV];
        a_pre = dt_cfg_q[pwos_pkg::DT_A_SWAP] ? b_dt : a_dt;
        b_pre = dt_cfg_q[pwos_pkg::DT_B_SWAP] ? a_dt : b_dt;
    end

    // ------------------------------------------------------------
    // carrier modulator
    // ------------------------------------------------------------
    logic [3:0] cr_div_q;
    logic cr_tick;
    logic [2:0] cr_ph_q;
    logic cr_wave;
    logic [1:0] cr_in;
    // unpacked so each generate branch owns its own element
    logic cr_prev_q [2];
    logic cr_out [2];
    logic [6:0] os_cnt_q [2];

    // carrier clock: one tick every divider+1 clock cycles
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            cr_div_q <= '0;
            cr_ph_q <= '0;
        end else if (CE) begin
            if (cr_tick) begin
                cr_div_q <= '0;
                cr_ph_q <= cr_ph_q + 1'b1;
            end else begin
                cr_div_q <= cr_div_q + 1'b1;
            end
        end
    end
    assign cr_tick = (cr_div_q >=
                      cr_cfg_q[pwos_pkg::CR_DIV_LSB +: 4]);
    // carrier runs 50% duty over a fixed number of ticks
    assign cr_wave = (cr_ph_q < 3'(pwos_pkg::CR_PERIOD_TICKS / 2));
    assign cr_in = {b_pre, a_pre} ^
                   {2{cr_cfg_q[pwos_pkg::CR_IN_INV]}};

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_car
            // first pulse held solid for the programmed periods
            always_ff @(posedge CLK) begin
                if (!RST_N) begin
                    os_cnt_q[g] <= '0;
                    cr_prev_q[g] <= 1'b0;
                end else if (CE) begin
                    cr_prev_q[g] <= cr_in[g];
                    if (cr_in[g] && !cr_prev_q[g]) begin
                        os_cnt_q[g] <= {cr_cfg_q[pwos_pkg::CR_WIDTH_LSB +: 4],
                                        3'h0};
                    end else if (!cr_in[g]) begin
                        os_cnt_q[g] <= '0;
                    end else if (cr_tick && os_cnt_q[g] != 7'h00) begin
                        os_cnt_q[g] <= os_cnt_q[g] - 1'b1;
                    end
                end
            end
            assign cr_out[g] = cr_cfg_q[pwos_pkg::CR_ENABLE] ?
                ((cr_in[g] & ((os_cnt_q[g] != 7'h00) | cr_wave)) ^
                 cr_cfg_q[pwos_pkg::CR_OUT_INV]) :
                (g == 0 ? a_pre : b_pre);
        end
    endgenerate

    // ------------------------------------------------------------
    // fault handler
    // ------------------------------------------------------------
    logic [2:0] flt;
    logic os_pulse, cyc_pulse, clr_pulse, os_trig, cyc_trig, refresh;
    logic [1:0] os_a, os_b, cy_a, cy_b;
    logic [3:0] act_base;

    assign flt = {FAULT_EVENT_TWO, FAULT_EVENT_ONE, FAULT_EVENT_ZERO};

    // remember force bits to see software toggles
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            ff_prev_q <= pwos_pkg::RST_ZERO;
        end else if (CE) begin
            ff_prev_q <= ff_cfg_q;
        end
    end
    assign os_pulse = ff_cfg_q[pwos_pkg::FF_ONE_SHOT_TOGGLE] ^
                      ff_prev_q[pwos_pkg::FF_ONE_SHOT_TOGGLE];
    assign cyc_pulse = ff_cfg_q[pwos_pkg::FF_CYCLE_TOGGLE] ^
                       ff_prev_q[pwos_pkg::FF_CYCLE_TOGGLE];
    assign clr_pulse = ff_cfg_q[pwos_pkg::FF_CLEAR_TOGGLE] ^
                       ff_prev_q[pwos_pkg::FF_CLEAR_TOGGLE];

    // fault bit order: event zero, one, two from msb to lsb
    assign os_trig = |({flt[0], flt[1], flt[2]} &
                       fa_cfg_q[pwos_pkg::FA_F_ONE_SHOT_LSB +: 3]) |
                     (os_pulse & fa_cfg_q[pwos_pkg::FA_SW_ONE_SHOT_EN]);
    assign cyc_trig = |({flt[0], flt[1], flt[2]} &
                        fa_cfg_q[pwos_pkg::FA_F_CYCLE_LSB +: 3]) |
                      (cyc_pulse & fa_cfg_q[pwos_pkg::FA_SW_CYCLE_EN]);
    assign refresh = (ff_cfg_q[pwos_pkg::FF_REFRESH_LSB] & TIMER_ZERO_MATCH) |
                     (ff_cfg_q[pwos_pkg::FF_REFRESH_LSB + 1] &
                      TIMER_PERIOD_MATCH);

    // a new trip wins over a clear in the same cycle
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            os_on_q <= 1'b0;
            cyc_on_q <= 1'b0;
        end else if (CE) begin
            os_on_q <= os_trig | (os_on_q & ~clr_pulse);
            cyc_on_q <= cyc_trig | (cyc_on_q & ~refresh);
        end
    end

    // per-direction action fields: cycle d, cycle u, shot d, shot u
    assign act_base = TIMER_COUNT_DOWN ? 4'h0 : 4'h2;
    assign cy_a = fa_cfg_q[pwos_pkg::FA_A_ACT_LSB + 32'(act_base) +: 2];
    assign os_a = fa_cfg_q[pwos_pkg::FA_A_ACT_LSB + 4 + 32'(act_base) +: 2];
    assign cy_b = fa_cfg_q[pwos_pkg::FA_B_ACT_LSB + 32'(act_base) +: 2];
    assign os_b = fa_cfg_q[pwos_pkg::FA_B_ACT_LSB + 4 + 32'(act_base) +: 2];

    // one-shot forcing takes precedence over cycle forcing
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            OUTPUT_A <= 1'b0;
            OUTPUT_B <= 1'b0;
        end else if (CE) begin
            if (os_on_q) begin
                OUTPUT_A <= apply_act(cr_out[0], os_a);
                OUTPUT_B <= apply_act(cr_out[1], os_b);
            end else if (cyc_on_q) begin
                OUTPUT_A <= apply_act(cr_out[0], cy_a);
                OUTPUT_B <= apply_act(cr_out[1], cy_b);
            end else begin
                OUTPUT_A <= cr_out[0];
                OUTPUT_B <= cr_out[1];
            end
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);

    property p_os_set;
        CE && os_trig |=> os_on_q;
    endproperty
    a_os_set: assert property (p_os_set)
        else $error("one-shot trip not raised");

    property p_os_clear;
        CE && clr_pulse && !os_trig |=> !os_on_q;
    endproperty
    a_os_clear: assert property (p_os_clear)
        else $error("one-shot not cleared by toggle");

    property p_cyc_refresh;
        CE && refresh && !cyc_trig |=> !cyc_on_q;
    endproperty
    a_cyc_refresh: assert property (p_cyc_refresh)
        else $error("cycle trip not released at refresh");

    property p_sw_os;
        CE && os_pulse && fa_cfg_q[pwos_pkg::FA_SW_ONE_SHOT_EN] |=> os_on_q;
    endproperty
    a_sw_os: assert property (p_sw_os)
        else $error("software one-shot toggle ignored");

    property p_sw_cyc_off;
        CE && cyc_pulse && !fa_cfg_q[pwos_pkg::FA_SW_CYCLE_EN] && !cyc_on_q
            && flt == 3'h0 |=> !cyc_on_q;
    endproperty
    a_sw_cyc_off: assert property (p_sw_cyc_off)
        else $error("disabled software cycle trip accepted");

    property p_force_low;
        CE && os_on_q && os_a == pwos_pkg::ACT_LOW |=> !OUTPUT_A;
    endproperty
    a_force_low: assert property (p_force_low)
        else $error("one-shot low not applied on A");

    property p_bypass;
        CE && !cr_cfg_q[pwos_pkg::CR_ENABLE] && !os_on_q && !cyc_on_q
            |=> OUTPUT_B == $past(b_pre);
    endproperty
    a_bypass: assert property (p_bypass)
        else $error("disabled carrier altered output");

    property p_imm_update;
        CE && dt_cfg_q[pwos_pkg::DT_RISE_UPD_LSB +: 4] == 4'h0
            |=> red_act_q == $past(red_sh_q[DELAY_W-1:0]);
    endproperty
    a_imm_update: assert property (p_imm_update)
        else $error("rising delay not updated immediately");

    property p_b_high;
        CE && b_evt == 6'h01 && !TIMER_COUNT_DOWN
            && b_act_q[1:0] == pwos_pkg::ACT_HIGH |=> b_gen_q;
    endproperty
    a_b_high: assert property (p_b_high)
        else $error("output B zero-match high not applied");
endmodule : pwos_top

/* File: pwos_gate_model.sv */
`timescale 1ns/10ps
// ------------------------------------------------------------
// gate driver pair seen by the output stage
// ------------------------------------------------------------
module pwos_gate_model (
    // clock
    input wire logic clk,
    // gate inputs
    input wire logic gate_a,
    input wire logic gate_b,
    // switch state
    output logic switch_a_on,
    output logic switch_b_on
);
    // the driver latches its gate once a cycle, like a real level shifter
    always_ff @(posedge clk) begin
        switch_a_on <= gate_a;
        switch_b_on <= gate_b;
    end
endmodule : pwos_gate_model

/* File: testbench.sv */
`timescale 1ns/10ps
module testbench;
    logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, r;
    logic pready, pslverr, out_a, out_b, sw_b, dn = 0, exp_b = 0;
    logic sw_a, err, prev_a = 0;
    int hi_s = 0, hi_w = 0, rises = 0;
    logic [5:0] ev = 6'h00;
    logic [2:0] flt = 3'h0;
    int bad_count = 0, total_checks = 0;
    // ------------------------------------------------------------
    // clock, dut and gate driver
    // ------------------------------------------------------------
    initial forever #2.5 clk = ~clk;
    pwos_top i_dut (.CLK(clk), .RST_N(rst_n), .CE(1'b1), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
        .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .TIMER_ZERO_MATCH(ev[0]), .TIMER_PERIOD_MATCH(ev[1]),
        .COMPARE_A_MATCH(ev[2]), .COMPARE_B_MATCH(ev[3]),
        .TRIGGER_EVENT_ZERO(ev[4]), .TRIGGER_EVENT_ONE(ev[5]),
        .TIMER_COUNT_DOWN(dn), .SYNC_EVENT(1'b0),
        .TIMER_PRESCALED_CLOCK(1'b0), .FAULT_EVENT_ZERO(flt[0]),
        .FAULT_EVENT_ONE(flt[1]), .FAULT_EVENT_TWO(flt[2]),
        .OUTPUT_A_IN(1'b0), .OUTPUT_A(out_a), .OUTPUT_B(out_b));
    pwos_gate_model i_gate (.clk(clk), .gate_a(out_a), .gate_b(out_b),
        .switch_a_on(sw_a), .switch_b_on(sw_b));
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task end_of_test;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : end_of_test
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] e);
        total_checks++;
        if (seen !== e) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", nm, e, seen);
        end
    endtask : chk
    // request held from setup until pready is sampled high
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 0;
        @(posedge clk);
        penable <= 1;
        do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 20);
        r = prdata;
        err = pslverr;
        if (n >= 20) begin bad_count++; end_of_test(); end
        psel <= 0;
        penable <= 0;
    endtask : apb
    // one-cycle event pulse, then let the output pipeline settle
    task fire(input int i);
        @(posedge clk); ev[i] <= 1'b1;
        @(posedge clk); ev <= 6'h00;
        repeat (6) @(posedge clk);
    endtask : fire
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1;
        apb(0, pwos_pkg::OFF_DEADTIME_CONFIG, 0);
        chk("deadtime_config", r, pwos_pkg::RST_DEADTIME_CONFIG);
        apb(0, 12'h0F0, 0);
        chk("unmapped slverr", {31'h0, err}, 32'h1);
        chk("unmapped data", r, 32'h0);
        apb(1, pwos_pkg::OFF_FALLING_DELAY_SHADOW, 32'h0000_1234);
        apb(0, pwos_pkg::OFF_FALLING_DELAY_SHADOW, 0);
        chk("fall shadow", r, 32'h0000_1234);
        // action codes high, keep, low, toggle on timer zero
        for (int k = 0; k < 4; k++) begin
            logic [1:0] c;
            c = k == 0 ? 2'd2 : k == 1 ? 2'd0 : k == 2 ? 2'd1 : 2'd3;
            apb(1, pwos_pkg::OFF_OUTPUT_B_ACTIONS, {30'h0, c});
            fire(0);
            exp_b = c == 2'd1 ? 1'b0 : c == 2'd2 ? 1'b1 : c[0] ^ exp_b;
            chk("output b code", {31'h0, out_b}, {31'h0, exp_b});
        end
        // every trigger toggles through its own up field
        for (int i = 0; i < 6; i++) begin
            apb(1, pwos_pkg::OFF_OUTPUT_B_ACTIONS, 32'h3 << (2 * i));
            fire(i);
            exp_b = ~exp_b;
            chk("output b trigger", {31'h0, out_b}, {31'h0, exp_b});
        end
        // counting down picks the down field, not the up one
        dn <= 1;
        apb(1, pwos_pkg::OFF_OUTPUT_B_ACTIONS, 32'h0000_2001);
        fire(0);
        chk("output b down", {31'h0, out_b}, 32'h1);
        dn <= 0;
        // software one-shot forcing B low, then cleared
        apb(1, pwos_pkg::OFF_FAULT_ACTION_CONFIG, 32'h0040_0010);
        apb(1, pwos_pkg::OFF_FAULT_FORCE_CONFIG, 32'h10);
        repeat (6) @(posedge clk);
        chk("b one shot", {31'h0, out_b}, 32'h0);
        apb(0, pwos_pkg::OFF_FAULT_STATUS, 0);
        chk("shot flag", r, 32'h2);
        apb(1, pwos_pkg::OFF_FAULT_FORCE_CONFIG, 32'h11);
        repeat (6) @(posedge clk);
        apb(0, pwos_pkg::OFF_FAULT_STATUS, 0);
        chk("shot cleared", r, 32'h0);
        // toggling with the software enable off is ignored
        apb(1, pwos_pkg::OFF_FAULT_ACTION_CONFIG, 32'h0);
        apb(1, pwos_pkg::OFF_FAULT_FORCE_CONFIG, 32'h01);
        repeat (6) @(posedge clk);
        apb(0, pwos_pkg::OFF_FAULT_STATUS, 0);
        chk("shot gated", r, 32'h0);
        // fault zero cycle trip, released at period match
        apb(1, pwos_pkg::OFF_FAULT_ACTION_CONFIG, 32'h0000_0808);
        apb(1, pwos_pkg::OFF_FAULT_FORCE_CONFIG, 32'h05);
        flt <= 3'h1;
        repeat (4) @(posedge clk);
        apb(0, pwos_pkg::OFF_FAULT_STATUS, 0);
        chk("cycle flag", r, 32'h1);
        chk("a cycle high", {31'h0, out_a}, 32'h1);
        flt <= 3'h0;
        fire(1);
        apb(0, pwos_pkg::OFF_FAULT_STATUS, 0);
        chk("cycle released", r, 32'h0);
        chk("a released", {31'h0, out_a}, 32'h0);
        chk("driver a", {31'h0, sw_a}, 32'h0);
        chk("driver b", {31'h0, sw_b}, 32'h1);
        // carrier enabled with output invert only: idle A reads high
        apb(1, pwos_pkg::OFF_CARRIER_CONFIG, 32'h0000_1001);
        repeat (3) @(posedge clk);
        chk("carrier out inv", {31'h0, out_a}, 32'h1);
        // input invert raises A: one solid period, then 16-cycle carrier
        apb(1, pwos_pkg::OFF_CARRIER_CONFIG, 32'h0000_2103);
        for (int k = 1; k < 52; k++) begin
            @(posedge clk);
            if (k >= 3 && k < 15) hi_s += out_a;
            if (k >= 20) begin
                hi_w += out_a;
                rises += out_a & ~prev_a;
            end
            prev_a = out_a;
        end
        chk("first pulse", hi_s, 32'd12);
        chk("carrier duty", hi_w, 32'd16);
        chk("carrier period", rises, 32'd2);
        end_of_test();
    end
endmodule : testbench
